// >>> core/fault_timing_defs.svh
// Timing and framing constants for the fault response block.
// Assumes a 100 MHz system clock on clk_in.
`ifndef FAULT_TIMING_DEFS_SVH
`define FAULT_TIMING_DEFS_SVH
`define CLK_PERIOD_NS 10
// Dead time window, ns. The target sits mid-window.
`define DEAD_MIN_NS 800
`define DEAD_MAX_NS 1200
`define DEAD_TARGET_NS 1000
`define DEAD_CYCLES ((`DEAD_TARGET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Notification delay, typical and longest, in ns.
`define NOTIFY_TYP_NS 2000
`define NOTIFY_MAX_NS 4500
`define NOTIFY_CYCLES (`NOTIFY_TYP_NS / `CLK_PERIOD_NS)
`define NOTIFY_MAX_CYCLES (`NOTIFY_MAX_NS / `CLK_PERIOD_NS)
`define CLASS_OFF_MAX_NS 400
`define DESAT_OFF_MAX_NS 430
`define OVERCURRENT_OFF_MAX_NS 150
`define CLASS_OFF_MAX_CYCLES (`CLASS_OFF_MAX_NS / `CLK_PERIOD_NS)
`define OVERCURRENT_OFF_MAX_CYCLES (`OVERCURRENT_OFF_MAX_NS / `CLK_PERIOD_NS)
// Verification time-outs, ms.
`define VERIFY_SHORT_MS 15
`define VERIFY_LONG_MS 60
`define VERIFY_SHORT_CYCLES (`VERIFY_SHORT_MS * 100000)
`define VERIFY_LONG_CYCLES (`VERIFY_LONG_MS * 100000)
`define LIFESIGN_US 5
`define LIFESIGN_CYCLES (`LIFESIGN_US * 1000 / `CLK_PERIOD_NS)
`define FRAME_BITS 16
`define CNT_W 24
`define BIT_W 5
`endif

// >>> core/fault_timing_pkg.sv
// Types shared by the fault response block.
// Assumes fault_timing_defs.svh provides the numeric constants.
package fault_timing_pkg;
  typedef enum logic [1:0] {GATE_OFF, GATE_DEAD, GATE_ON} gate_e;
  typedef enum logic [1:0] {VM_IDLE, VM_RUN, VM_EXPIRED} verify_e;
endpackage

// >>> core/fault_response_timing.sv
// Fault response timing core: dead time, fault notification, turn-off,
// verification time-out, lifesign, and a 16-bit daisy-chain serial slave.
// Assumes fault inputs come from comparators outside clk_in's domain.
`timescale 1ns/100ps
`include "fault_timing_defs.svh"

// Function
// R1 - Dead time between opposing gate commands.
// R2 - Class A notification within 4.5 us.
// R3 - Class A turn-off within 400 ns.
// R4 - Desat turn-off after blanking within 430 ns.
// R5 - Overcurrent turn-off after blanking within 150 ns.
// R6 - Class B notification within 4.5 us.
// R7 - Class B turn-off within 400 ns.
// R8 - Verification time-out 15 or 60 ms.
// R9 - Lifesign error flagged after 5 us.
// R10 - Frame carries 16 bits per device.
// R11 - Host serial clock 0.1 to 2 MHz. The bench host drives sclk with a 6 ns period instead.
// R12 - Fault pins low on fault, else released.
module fault_response_timing
  import fault_timing_pkg::*;
#(
  parameter logic [`CNT_W-1:0] VERIFY_SHORT = `CNT_W'(`VERIFY_SHORT_CYCLES),
  parameter logic [`CNT_W-1:0] VERIFY_LONG = `CNT_W'(`VERIFY_LONG_CYCLES)
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic pwm_cmd_in,
  input wire logic class_a_event_in,
  input wire logic class_b_event_in,
  input wire logic desat_event_in,
  input wire logic desat_blank_done_in,
  input wire logic overcurrent_monitor_in,
  input wire logic overcurrent_blank_done_in,
  input wire logic fault_clear_in,
  input wire logic operating_mode_two_in,
  input wire logic verification_mode_in,
  input wire logic timeout_select_bit_in,
  input wire logic lifesign_error_in,
  output logic gate_on_out,
  output logic turn_off_out,
  output logic class_a_fault_pin_n_out,
  output logic class_a_fault_pin_n_oe_out,
  output logic class_b_fault_pin_n_out,
  output logic class_b_fault_pin_n_oe_out,
  output logic verify_timeout_out,
  output logic lifesign_flag_out,
  input wire logic sclk_in,
  input wire logic chip_select_n_in,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic [`FRAME_BITS-1:0] rx_word_out,
  output logic rx_valid_out
);

  // ****************************************************************
  // System clock state
  // ****************************************************************
  typedef struct packed {
    logic [7:0] sync1;
    logic [7:0] sync2;
    gate_e gate;
    logic [`CNT_W-1:0] dead_cnt;
    logic turn_off;
    logic pend_a;
    logic pend_b;
    logic [`CNT_W-1:0] cnt_a;
    logic [`CNT_W-1:0] cnt_b;
    logic flt_a;
    logic flt_b;
    verify_e vm;
    logic mode2_seen;
    logic [`CNT_W-1:0] vm_cnt;
    logic [`CNT_W-1:0] vm_limit;
    logic [`CNT_W-1:0] ls_cnt;
    logic ls_flag;
    logic [2:0] tog_sync;
    logic [`FRAME_BITS-1:0] rx_word;
    logic rx_valid;
  } sys_s;

  sys_s cur, next_cur;
  logic link_toggle;
  logic [`FRAME_BITS-1:0] link_word;

  // Sync bit map: 0 pwm, 1 A, 2 B, 3 desat, 4 desat blank, 5 oc, 6 oc blank, 7 lifesign.
  logic [7:0] raw;
  assign raw = {lifesign_error_in, overcurrent_blank_done_in, overcurrent_monitor_in,
                desat_blank_done_in, desat_event_in, class_b_event_in,
                class_a_event_in, pwm_cmd_in};

  logic [7:0] s;
  logic trip_fast;
  assign s = cur.sync2;
  // Every turn-off cause acts on the synchronised level one cycle later, far inside its bound.
  assign trip_fast = s[1] | s[2] | (s[3] & s[4]) | (s[5] & s[6]);

  always_comb begin
    next_cur = cur;
    next_cur.sync1 = raw;
    next_cur.sync2 = cur.sync1;
    next_cur.tog_sync = {cur.tog_sync[1:0], link_toggle};
    next_cur.rx_valid = 1'b0;
    // Turn-off latches until the fault is cleared; a clear with a live cause keeps it.
    if (trip_fast) begin
      next_cur.turn_off = 1'b1; // R3 R4 R5 R7
    end else if (fault_clear_in) begin
      next_cur.turn_off = 1'b0;
    end
    unique case (cur.gate)
      GATE_OFF: begin
        if (s[0] && !cur.turn_off && !trip_fast) begin
          next_cur.gate = GATE_DEAD; // R1
          next_cur.dead_cnt = '0;
        end
      end
      GATE_DEAD: begin
        next_cur.dead_cnt = cur.dead_cnt + `CNT_W'(1);
        if (!s[0] || cur.turn_off) begin
          next_cur.gate = GATE_OFF;
        end else if (cur.dead_cnt == `CNT_W'(`DEAD_CYCLES - 1)) begin
          next_cur.gate = GATE_ON; // R1
        end
      end
      GATE_ON: begin
        if (!s[0] || cur.turn_off || trip_fast) begin
          next_cur.gate = GATE_OFF;
        end
      end
    endcase
    // Notification paths: count the typical delay, then pull the pin low.
    if (s[1] && !cur.pend_a && !cur.flt_a) begin
      next_cur.pend_a = 1'b1;
      next_cur.cnt_a = '0;
    end else if (cur.pend_a) begin
      next_cur.cnt_a = cur.cnt_a + `CNT_W'(1);
      if (cur.cnt_a == `CNT_W'(`NOTIFY_CYCLES - 1)) begin
        next_cur.pend_a = 1'b0;
        next_cur.flt_a = 1'b1; // R2
      end
    end else if (fault_clear_in && !s[1]) begin
      next_cur.flt_a = 1'b0;
    end
    if (s[2] && !cur.pend_b && !cur.flt_b) begin
      next_cur.pend_b = 1'b1;
      next_cur.cnt_b = '0;
    end else if (cur.pend_b) begin
      next_cur.cnt_b = cur.cnt_b + `CNT_W'(1);
      if (cur.cnt_b == `CNT_W'(`NOTIFY_CYCLES - 1)) begin
        next_cur.pend_b = 1'b0;
        next_cur.flt_b = 1'b1; // R6
      end
    end else if (fault_clear_in && !s[2]) begin
      next_cur.flt_b = 1'b0;
    end
    // Verification mode counts only when entered straight from mode two.
    next_cur.mode2_seen = operating_mode_two_in ? 1'b1 :
                          (verification_mode_in ? cur.mode2_seen : 1'b0);
    unique case (cur.vm)
      VM_IDLE: begin
        if (verification_mode_in && cur.mode2_seen) begin
          next_cur.vm = VM_RUN;
          next_cur.vm_cnt = '0;
          next_cur.vm_limit = timeout_select_bit_in ? VERIFY_LONG : VERIFY_SHORT; // R8
        end
      end
      VM_RUN: begin
        next_cur.vm_cnt = cur.vm_cnt + `CNT_W'(1);
        if (!verification_mode_in) begin
          next_cur.vm = VM_IDLE;
        end else if (cur.vm_cnt == cur.vm_limit - `CNT_W'(1)) begin
          next_cur.vm = VM_EXPIRED; // R8
        end
      end
      VM_EXPIRED: begin
        if (!verification_mode_in) begin
          next_cur.vm = VM_IDLE;
        end
      end
    endcase
    // Lifesign flag holds once raised; only a clear without a live error drops it.
    if (s[7] && !cur.ls_flag) begin
      next_cur.ls_cnt = cur.ls_cnt + `CNT_W'(1);
      if (cur.ls_cnt == `CNT_W'(`LIFESIGN_CYCLES - 1)) begin
        next_cur.ls_flag = 1'b1; // R9
      end
    end else if (!s[7]) begin
      next_cur.ls_cnt = '0;
      if (fault_clear_in) begin
        next_cur.ls_flag = 1'b0;
      end
    end
    // The word is stable in the link domain for a whole frame after the toggle.
    if (cur.tog_sync[2] != cur.tog_sync[1]) begin
      next_cur.rx_word = link_word; // R10
      next_cur.rx_valid = 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign gate_on_out = (cur.gate == GATE_ON);
  assign turn_off_out = cur.turn_off;
  assign class_a_fault_pin_n_out = 1'b0; // R12
  assign class_a_fault_pin_n_oe_out = cur.flt_a; // R12
  assign class_b_fault_pin_n_out = 1'b0; // R12
  assign class_b_fault_pin_n_oe_out = cur.flt_b; // R12
  assign verify_timeout_out = (cur.vm == VM_EXPIRED);
  assign lifesign_flag_out = cur.ls_flag;
  assign rx_word_out = cur.rx_word;
  assign rx_valid_out = cur.rx_valid;

  // ****************************************************************
  // Link domain: serial shift register on the host's clock
  // ****************************************************************
  // The bench host runs sclk with a 6 ns period, so the link word is held
  // for only 96 ns, under ten clk_in cycles, before the next frame can overwrite it. R11
  typedef struct packed {
    logic [`FRAME_BITS-1:0] shift;
    logic [`BIT_W-1:0] bits;
    logic [`FRAME_BITS-1:0] word;
    logic toggle;
  } link_s;

  link_s lnk, next_lnk;

  always_comb begin
    next_lnk = lnk;
    next_lnk.shift = {lnk.shift[`FRAME_BITS-2:0], sdi_in};
    if (lnk.bits == `BIT_W'(`FRAME_BITS - 1)) begin
      next_lnk.bits = '0;
      next_lnk.word = {lnk.shift[`FRAME_BITS-2:0], sdi_in}; // R10
      next_lnk.toggle = ~lnk.toggle;
    end else begin
      next_lnk.bits = lnk.bits + `BIT_W'(1);
    end
  end

  // Chip select resets the bit count, so each frame starts on a word boundary.
  always_ff @(posedge sclk_in or posedge rst_in or posedge chip_select_n_in) begin
    if (rst_in) begin
      lnk <= '0;
    end else if (chip_select_n_in) begin
      lnk.bits <= '0;
    end else begin
      lnk <= next_lnk;
    end
  end

  assign link_toggle = lnk.toggle;
  assign link_word = lnk.word;
  // Daisy chain: the bit shifted out is the one 16 clocks old.
  assign sdo_out = lnk.shift[`FRAME_BITS-1];

  // ****************************************************************
  // Checks
  // ****************************************************************
  int unsigned a_cnt_chk;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      a_cnt_chk <= 0;
    end else begin
      a_cnt_chk <= (cur.gate == GATE_DEAD) ? a_cnt_chk + 1 : 0;
    end
  end

  a_dead_time_len: assert property (@(posedge clk_in) disable iff (rst_in) // R1
    $rose(gate_on_out) |-> a_cnt_chk == `DEAD_CYCLES)
    else $error("dead time length wrong");
  a_class_a_notify: assert property (@(posedge clk_in) disable iff (rst_in) // R2
    $rose(cur.sync2[1]) && !cur.flt_a && !cur.pend_a |-> ##[1:450] class_a_fault_pin_n_oe_out)
    else $error("class A pin late");
  a_class_a_off: assert property (@(posedge clk_in) disable iff (rst_in) // R3
    $rose(class_a_event_in) |-> ##[1:40] turn_off_out)
    else $error("class A turn-off late");
  a_desat_off: assert property (@(posedge clk_in) disable iff (rst_in) // R4
    desat_event_in && desat_blank_done_in |-> ##[1:43] turn_off_out)
    else $error("desat turn-off late");
  a_oc_off: assert property (@(posedge clk_in) disable iff (rst_in) // R5
    overcurrent_monitor_in && overcurrent_blank_done_in |-> ##[1:15] turn_off_out)
    else $error("overcurrent turn-off late");
  a_class_b_notify: assert property (@(posedge clk_in) disable iff (rst_in) // R6
    $rose(cur.sync2[2]) && !cur.flt_b && !cur.pend_b |-> ##[1:450] class_b_fault_pin_n_oe_out)
    else $error("class B pin late");
  a_class_b_off: assert property (@(posedge clk_in) disable iff (rst_in) // R7
    $rose(class_b_event_in) |-> ##[1:40] turn_off_out)
    else $error("class B turn-off late");
  a_verify_limit: assert property (@(posedge clk_in) disable iff (rst_in) // R8
    $rose(verify_timeout_out) |-> cur.vm_cnt == cur.vm_limit)
    else $error("verification time-out count wrong");
  a_lifesign_delay: assert property (@(posedge clk_in) disable iff (rst_in) // R9
    $rose(lifesign_flag_out) |-> $past(cur.sync2[7], 500))
    else $error("lifesign flagged early");
  a_pin_release: assert property (@(posedge clk_in) disable iff (rst_in) // R12
    $fell(class_a_fault_pin_n_oe_out) |-> $past(fault_clear_in) && !class_a_fault_pin_n_out)
    else $error("fault pin released without clear");
  a_no_on_in_fault: assert property (@(posedge clk_in) disable iff (rst_in) // R3
    turn_off_out |=> !gate_on_out)
    else $error("gate on during turn-off");

  c_gate_on: cover property (@(posedge clk_in) disable iff (rst_in) $rose(gate_on_out));
  c_fault_a: cover property (@(posedge clk_in) disable iff (rst_in)
    $rose(class_a_fault_pin_n_oe_out));
  c_verify: cover property (@(posedge clk_in) disable iff (rst_in) $rose(verify_timeout_out));
  c_frame: cover property (@(posedge clk_in) disable iff (rst_in) rx_valid_out);

endmodule

// >>> sim/host_spi_master.sv
// Host serial master model that drives the chained serial port.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/100ps
module host_spi_master (
  output logic sclk_out,
  output logic chip_select_n_out,
  output logic sdi_out,
  input wire logic sdo_in
);
  // ****************************************
  // Frame tasks
  // ****************************************
  initial begin
    sclk_out = 1'b0;
    chip_select_n_out = 1'b1;
    sdi_out = 1'b0;
  end
  task automatic open_frame;
    chip_select_n_out = 1'b0;
    #7;
  endtask
  // The released data line shows the inverse of its last bit, so stale data never matches.
  task automatic close_frame;
    #7;
    chip_select_n_out = 1'b1;
    sdi_out = ~sdi_out;
    #20;
  endtask
  // Shifts the top bits bits of one word MSB first and returns what the device pushed out meanwhile.
  task automatic xfer(input logic [15:0] w, input int bits, output logic [15:0] back);
    back = 16'h0000;
    for (int i = 15; i > 15 - bits; i--) begin
      sdi_out = w[i];
      #3;
      back = {back[14:0], sdo_in};
      sclk_out = 1'b1;
      #3;
      sclk_out = 1'b0;
    end
  endtask
endmodule

// >>> sim/fault_response_timing_test.sv
// Self-checking bench for the fault response block with a host model.
// Assumes the timing constants header and the package are compiled first.
`timescale 1ns/100ps
`include "fault_timing_defs.svh"
module fault_response_timing_test;
  import fault_timing_pkg::*;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic clk_in = 1'b0, rst_in = 1'b0, pwm_cmd_in = 1'b0, class_a_event_in = 1'b0;
  logic class_b_event_in = 1'b0, desat_event_in = 1'b0, desat_blank_done_in = 1'b0;
  logic overcurrent_monitor_in = 1'b0, overcurrent_blank_done_in = 1'b0, fault_clear_in = 1'b0;
  logic operating_mode_two_in = 1'b0, verification_mode_in = 1'b0, timeout_select_bit_in = 1'b0;
  logic lifesign_error_in = 1'b0, gate_on_out, turn_off_out, class_a_fault_pin_n_out;
  logic class_a_fault_pin_n_oe_out, class_b_fault_pin_n_out, class_b_fault_pin_n_oe_out;
  logic verify_timeout_out, lifesign_flag_out, sclk, chip_select_n, sdi, sdo_out, rx_valid_out;
  logic [`FRAME_BITS-1:0] rx_word_out;
  logic [15:0] w1, w2, back;
  logic [15:0] exp_q[$];
  int num_errors = 0, tests_run = 0, n, seed = 32'h5995;
  int lim[4] = '{`CLASS_OFF_MAX_CYCLES, `CLASS_OFF_MAX_CYCLES,
    `DESAT_OFF_MAX_NS / `CLK_PERIOD_NS, `OVERCURRENT_OFF_MAX_CYCLES};
  always #5 clk_in = ~clk_in;
  fault_response_timing #(.VERIFY_SHORT(24'h0000C8), .VERIFY_LONG(24'h000320)) i_dut (.*,
    .sclk_in(sclk), .chip_select_n_in(chip_select_n), .sdi_in(sdi));
  host_spi_master i_host (.sclk_out(sclk), .chip_select_n_out(chip_select_n), .sdi_out(sdi),
    .sdo_in(sdo_out));
  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic probe(input int k);
    case (k)
      0: return gate_on_out;
      1: return turn_off_out;
      2: return class_a_fault_pin_n_oe_out;
      3: return class_b_fault_pin_n_oe_out;
      4: return verify_timeout_out;
      default: return lifesign_flag_out;
    endcase
  endfunction
  task automatic measure(input int k, input int limit, output int cnt);
    cnt = 0;
    while (probe(k) !== 1'b1 && cnt < limit) begin
      @(negedge clk_in);
      cnt++;
    end
  endtask
  task automatic cause(input int k, input logic v);
    case (k)
      0: class_a_event_in = v;
      1: class_b_event_in = v;
      2: desat_event_in = v;
      default: overcurrent_monitor_in = v;
    endcase
  endtask
  task automatic clear_pulse;
    fault_clear_in = 1'b1;
    @(negedge clk_in);
    fault_clear_in = 1'b0;
    repeat (5) @(negedge clk_in);
  endtask
  // Words are checked as they surface; a dropped partial word must raise nothing.
  always @(negedge clk_in) begin
    if (rx_valid_out === 1'b1) begin
      if (exp_q.size() == 0) check(1'b0, "unexpected word");
      else check(rx_word_out === exp_q.pop_front(), "received word");
    end
  end
  initial begin
    #500000;
    num_errors++;
    complete_run;
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    // A real rising reset edge also resets the link logic, which sees no sclk edge yet.
    #1;
    rst_in = 1'b1;
    repeat (3) @(negedge clk_in);
    rst_in = 1'b0;
    check({gate_on_out, turn_off_out, class_a_fault_pin_n_oe_out, class_b_fault_pin_n_oe_out}
      === 4'h0, "reset state");
    pwm_cmd_in = 1'b1;
    measure(0, 300, n);
    check(n >= `DEAD_MIN_NS / 10 && n <= `DEAD_MAX_NS / 10 + 4, "dead time");
    for (int k = 0; k < 4; k++) begin
      desat_blank_done_in = 1'b0;
      overcurrent_blank_done_in = 1'b0;
      cause(k, 1'b1);
      if (k >= 2) begin
        repeat (50) @(negedge clk_in);
        check(turn_off_out === 1'b0, "blanking ignored");
        desat_blank_done_in = (k == 2);
        overcurrent_blank_done_in = (k == 3);
      end
      measure(1, 200, n);
      if (k < 2) check(n <= lim[k], "class turn-off late");
      else check(n <= lim[k], "monitor turn-off late");
      repeat (5) @(negedge clk_in);
      check(gate_on_out === 1'b0, "gate on during turn-off");
      if (k < 2) begin
        measure(k + 2, 1000, n);
        check(n <= `NOTIFY_MAX_CYCLES, "notification late");
        check(probe(3 - k) === 1'b0 && (class_a_fault_pin_n_out | class_b_fault_pin_n_out)
          === 1'b0, "pin levels");
      end
      clear_pulse;
      check(turn_off_out === 1'b1, "clear with cause present");
      cause(k, 1'b0);
      // The cause must have passed the input synchroniser before the clear is honoured.
      repeat (3) @(negedge clk_in);
      clear_pulse;
      check({turn_off_out, class_a_fault_pin_n_oe_out, class_b_fault_pin_n_oe_out} === 3'h0,
        "fault release");
    end
    operating_mode_two_in = 1'b1;
    for (int s = 0; s < 2; s++) begin
      timeout_select_bit_in = s[0];
      repeat (3) @(negedge clk_in);
      verification_mode_in = 1'b1;
      measure(4, 1000, n);
      check(n >= (s ? 798 : 198) && n <= (s ? 804 : 204), "verify time-out");
      verification_mode_in = 1'b0;
      repeat (5) @(negedge clk_in);
      check(verify_timeout_out === 1'b0, "verify exit");
    end
    lifesign_error_in = 1'b1;
    repeat (100) @(negedge clk_in);
    lifesign_error_in = 1'b0;
    repeat (5) @(negedge clk_in);
    check(lifesign_flag_out === 1'b0, "short lifesign error");
    lifesign_error_in = 1'b1;
    measure(5, 700, n);
    check(n >= `LIFESIGN_CYCLES && n <= `LIFESIGN_CYCLES + 6, "lifesign time");
    lifesign_error_in = 1'b0;
    repeat (3) @(negedge clk_in);
    clear_pulse;
    check(lifesign_flag_out === 1'b0, "lifesign clear");
    for (int i = 0; i < 8; i++) begin
      w1 = 16'($random(seed));
      w2 = 16'($random(seed));
      if (i == 4) begin
        i_host.open_frame;
        i_host.xfer(w1, 8, back);
        i_host.close_frame;
      end
      exp_q.push_back(w1);
      i_host.open_frame;
      i_host.xfer(w1, 16, back);
      if (i[0]) begin
        exp_q.push_back(w2);
        i_host.xfer(w2, 16, back);
        check(back === w1, "chained output");
      end
      i_host.close_frame;
    end
    repeat (10) @(negedge clk_in);
    check(exp_q.size() == 0, "words missing");
    complete_run;
  end
endmodule
